// [src/lpcfg_regs.svh]
// register offsets, field widths, reset values and timing counts of the polling config block
`ifndef LPCFG_REGS_SVH
`define LPCFG_REGS_SVH

// ----------------------------------------------------------------
// register addresses (7-bit frame address field)
// ----------------------------------------------------------------
`define LPCFG_ADDR_SG_CUR 7'h17
`define LPCFG_ADDR_SP_SLOW 7'h18
`define LPCFG_ADDR_SG_SLOW 7'h19
`define LPCFG_ADDR_SP_DEB 7'h1A

// ----------------------------------------------------------------
// field layout and reset values
// ----------------------------------------------------------------
`define LPCFG_SG_N 21
`define LPCFG_SP_N 12
`define LPCFG_SG_RST 21'h00_0000
`define LPCFG_SP_RST 12'h000
`define LPCFG_REPLY_RST 32'h0000_0000

// ----------------------------------------------------------------
// serial frame and timing
// ----------------------------------------------------------------
`define LPCFG_FRAME_BITS 6'h20
`define LPCFG_CNT_OVER 6'h21
`define LPCFG_SLOW_LAST 2'h3
`define LPCFG_DEB_EXT_US 1200
`define LPCFG_CLK_MHZ 100
`define LPCFG_ACTIVE_CYC 64
`define LPCFG_CNT_W 17

`endif

// [src/lpcfg_pkg.sv]
// types shared by the polling config block
package lpcfg_pkg;

  // polling current source selected for one channel
  typedef enum logic [1:0] {
    LPCFG_CUR_OFF = 2'h0,
    LPCFG_CUR_1MA = 2'h1,
    LPCFG_CUR_2MA = 2'h2,
    LPCFG_CUR_WET = 2'h3
  } lpcfg_cur_e;

  // per-channel poll sequencer states
  typedef enum logic [2:0] {
    LPCFG_ST_IDLE = 3'h1,
    LPCFG_ST_ACT = 3'h2,
    LPCFG_ST_EXT = 3'h4
  } lpcfg_st_e;

  // incoming command frame
  typedef struct packed {
    logic [6:0] addr;
    logic wr;
    logic [23:0] data;
  } lpcfg_frame_s;

  // outgoing reply word
  typedef struct packed {
    logic [6:0] addr;
    logic wr;
    logic fault;
    logic interrupt_pending_flag;
    logic [21:0] data;
  } lpcfg_reply_s;

endpackage

// [src/lpcfg_poll_chan.sv]
// one channel of the low-power polling sequencer
`timescale 1ns/10ps
`include "lpcfg_regs.svh"

module lpcfg_poll_chan import lpcfg_pkg::*; #(
  parameter bit HAS_DEB = 1'b0,
  parameter int ACT_CYC = `LPCFG_ACTIVE_CYC,
  parameter int DEB_CYC = `LPCFG_DEB_EXT_US * `LPCFG_CLK_MHZ
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // control
  input wire logic sleep_i,
  input wire logic tick_i,
  input wire logic slow_i,
  input wire logic deb_i,
  input wire logic wet_i,
  input wire logic batt_i,
  // results
  output lpcfg_cur_e cur_o,
  output logic sample_o,
  output logic final_o
);

  lpcfg_st_e st_q, st_d;
  logic [`LPCFG_CNT_W-1:0] cnt_q, cnt_d;
  logic [1:0] div_q, div_d;
  lpcfg_cur_e cur_q, cur_d;
  logic smp_q, smp_d;
  logic fin_q, fin_d;
  logic start;

  // normal-rate tick, or every fourth one when slowed
  assign start = tick_i && (!slow_i || div_q == `LPCFG_SLOW_LAST);

  // next state of the sequencer
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q + `LPCFG_CNT_W'(1);
    div_d = div_q;
    smp_d = 1'b0;
    fin_d = fin_q;
    // [RQ4] normal rate when not slowed
    // [RQ5] slow poll every fourth tick
    if (tick_i && slow_i) begin
      div_d = div_q + 2'h1;
    end
    case (st_q)
      LPCFG_ST_IDLE: begin
        cnt_d = '0;
        if (start) begin
          st_d = LPCFG_ST_ACT;
        end
      end
      LPCFG_ST_ACT: begin
        if (cnt_q == `LPCFG_CNT_W'(ACT_CYC - 1)) begin
          cnt_d = '0;
          // [RQ7] extend current when debounced
          if (HAS_DEB && deb_i) begin
            st_d = LPCFG_ST_EXT;
          end else begin
            // [RQ6] delta comparison without debounce
            st_d = LPCFG_ST_IDLE;
            smp_d = 1'b1;
            fin_d = 1'b0;
          end
        end
      end
      LPCFG_ST_EXT: begin
        if (cnt_q == `LPCFG_CNT_W'(DEB_CYC - 1)) begin
          // [RQ8] judge final voltage level
          st_d = LPCFG_ST_IDLE;
          smp_d = 1'b1;
          fin_d = 1'b1;
        end
      end
      default: begin
        st_d = LPCFG_ST_IDLE;
      end
    endcase
    if (!sleep_i) begin
      st_d = LPCFG_ST_IDLE;
      div_d = 2'h0;
      smp_d = 1'b0;
    end
  end

  // current source selection while polling
  always_comb begin
    cur_d = LPCFG_CUR_OFF;
    if (st_d != LPCFG_ST_IDLE) begin
      if (wet_i) begin
        // [RQ2] wetting level instead
        cur_d = LPCFG_CUR_WET;
      end else if (batt_i) begin
        // [RQ15] battery switch 2.0 mA
        cur_d = LPCFG_CUR_2MA;
      end else begin
        // [RQ1] ground switch 1.0 mA
        cur_d = LPCFG_CUR_1MA;
      end
    end
  end

  // sequencer registers
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_q <= LPCFG_ST_IDLE;
      cnt_q <= '0;
      div_q <= 2'h0;
      cur_q <= LPCFG_CUR_OFF;
      smp_q <= 1'b0;
      fin_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      div_q <= div_d;
      cur_q <= cur_d;
      smp_q <= smp_d;
      fin_q <= fin_d;
    end
  end

  assign cur_o = cur_q;
  assign sample_o = smp_q;
  assign final_o = fin_q;

endmodule

// [src/lpcfg_top.sv]
// serial-accessed low-power polling configuration registers with per-channel pollers
`timescale 1ns/10ps
`include "lpcfg_regs.svh"

// Operation
// [RQ1] ground channel bit 0: 1.0 mA polling
// [RQ2] bit 1: poll with wetting current level
// [RQ3] normal rate comes from external configuration
// [RQ4] slow bit 0: normal polling rate
// [RQ5] slow bit 1: poll four times less often
// [RQ6] debounce 0: voltage difference decision
// [RQ7] debounce 1: source current extra 1.2 ms
// [RQ8] debounced: judge voltage at interval end
// [RQ9] frame: address, write flag, 24 data
// [RQ10] reply: fault 23, interrupt 22, data
// [RQ11] ground current select at 0x17
// [RQ12] programmable slow poll at 0x18
// [RQ13] ground slow poll at 0x19
// [RQ14] programmable debounce at 0x1A
// [RQ15] battery switch 2.0 mA, ground 1.0
// [RQ16] reset clears bits, unused read zero
// [RQ17] write implemented bits only, reads harmless
module lpcfg_top import lpcfg_pkg::*; #(
  parameter int DEB_EXT_CYC = `LPCFG_DEB_EXT_US * `LPCFG_CLK_MHZ,
  parameter int ACTIVE_CYC = `LPCFG_ACTIVE_CYC
) (
  // clock and reset
  input wire logic REF_CLK_I,
  input wire logic RST_N_I,
  // serial port pins
  input wire logic SCLK_I,
  input wire logic CS_N_I,
  input wire logic MOSI_I,
  output logic MISO_O,
  output logic MISO_OE_N_O,
  // status flags from the rest of the device
  input wire logic FAULT_I,
  input wire logic INTERRUPT_PENDING_FLAG_I,
  // polling control
  input wire logic SLEEP_POLLING_STATE_I,
  input wire logic POLL_TICK_I,
  input wire logic [`LPCFG_SP_N-1:0] BATTERY_REFERENCED_SWITCH_I,
  // ground-switch channel outputs
  output lpcfg_cur_e [`LPCFG_SG_N-1:0] SG_CUR_O,
  output logic [`LPCFG_SG_N-1:0] SG_SAMPLE_O,
  // programmable channel outputs
  output lpcfg_cur_e [`LPCFG_SP_N-1:0] SP_CUR_O,
  output logic [`LPCFG_SP_N-1:0] SP_SAMPLE_O,
  output logic [`LPCFG_SP_N-1:0] SP_FINAL_O
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------

  logic sclk_s1_q, sclk_s2_q, sclk_s3_q;
  logic cs_s1_q, cs_s2_q, cs_s3_q;
  logic mosi_s1_q, mosi_s2_q;
  logic sclk_rise, sclk_fall;
  logic cs_fall, cs_rise;

  // two flops per pin, a third for edges
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      sclk_s1_q <= 1'b0;
      sclk_s2_q <= 1'b0;
      sclk_s3_q <= 1'b0;
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_s3_q <= 1'b1;
      mosi_s1_q <= 1'b0;
      mosi_s2_q <= 1'b0;
    end else begin
      sclk_s1_q <= SCLK_I;
      sclk_s2_q <= sclk_s1_q;
      sclk_s3_q <= sclk_s2_q;
      cs_s1_q <= CS_N_I;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
      mosi_s1_q <= MOSI_I;
      mosi_s2_q <= mosi_s1_q;
    end
  end

  // edge events on the synchronised pins
  assign sclk_rise = sclk_s2_q && !sclk_s3_q && !cs_s2_q;
  assign sclk_fall = !sclk_s2_q && sclk_s3_q && !cs_s2_q;
  assign cs_fall = !cs_s2_q && cs_s3_q;
  assign cs_rise = cs_s2_q && !cs_s3_q;

  // ----------------------------------------------------------------
  // frame receive and reply shift
  // ----------------------------------------------------------------

  logic [31:0] rx_q, rx_d;
  logic [31:0] tx_q, tx_d;
  logic [31:0] reply_q, reply_d;
  logic [5:0] bit_cnt_q, bit_cnt_d;
  lpcfg_frame_s frm;
  logic frame_done;

  assign frm = lpcfg_frame_s'(rx_q);

  // [RQ9] accept only whole 32-bit frames
  assign frame_done = cs_rise && bit_cnt_q == `LPCFG_FRAME_BITS;

  // shift registers, msb first
  always_comb begin
    rx_d = rx_q;
    tx_d = tx_q;
    bit_cnt_d = bit_cnt_q;
    if (cs_fall) begin
      bit_cnt_d = 6'h00;
      tx_d = reply_q;
    end else begin
      if (sclk_rise) begin
        // [RQ9] address first, then flag, data
        rx_d = {rx_q[30:0], mosi_s2_q};
        if (bit_cnt_q != `LPCFG_CNT_OVER) begin
          bit_cnt_d = bit_cnt_q + 6'h01;
        end
      end
      if (sclk_fall) begin
        tx_d = {tx_q[30:0], 1'b0};
      end
    end
  end

  // shift register flops
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      rx_q <= 32'h0000_0000;
      tx_q <= `LPCFG_REPLY_RST;
      bit_cnt_q <= 6'h00;
    end else begin
      rx_q <= rx_d;
      tx_q <= tx_d;
      bit_cnt_q <= bit_cnt_d;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------

  logic [`LPCFG_SG_N-1:0] sg_cur_q, sg_cur_d;
  logic [`LPCFG_SP_N-1:0] sp_slow_q, sp_slow_d;
  logic [`LPCFG_SG_N-1:0] sg_slow_q, sg_slow_d;
  logic [`LPCFG_SP_N-1:0] sp_deb_q, sp_deb_d;

  // register writes on a completed write frame
  always_comb begin
    sg_cur_d = sg_cur_q;
    sp_slow_d = sp_slow_q;
    sg_slow_d = sg_slow_q;
    sp_deb_d = sp_deb_q;
    // [RQ17] only implemented bits change
    if (frame_done && frm.wr) begin
      case (frm.addr)
        // [RQ11] ground current select
        `LPCFG_ADDR_SG_CUR: begin
          sg_cur_d = frm.data[`LPCFG_SG_N-1:0];
        end
        // [RQ12] programmable slow poll
        `LPCFG_ADDR_SP_SLOW: begin
          sp_slow_d = frm.data[`LPCFG_SP_N-1:0];
        end
        // [RQ13] ground slow poll
        `LPCFG_ADDR_SG_SLOW: begin
          sg_slow_d = frm.data[`LPCFG_SG_N-1:0];
        end
        // [RQ14] programmable debounce
        `LPCFG_ADDR_SP_DEB: begin
          sp_deb_d = frm.data[`LPCFG_SP_N-1:0];
        end
        default: begin
          sg_cur_d = sg_cur_q;
        end
      endcase
    end
  end

  // register flops
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      // [RQ16] all channel bits clear
      sg_cur_q <= `LPCFG_SG_RST;
      sp_slow_q <= `LPCFG_SP_RST;
      sg_slow_q <= `LPCFG_SG_RST;
      sp_deb_q <= `LPCFG_SP_RST;
    end else begin
      sg_cur_q <= sg_cur_d;
      sp_slow_q <= sp_slow_d;
      sg_slow_q <= sg_slow_d;
      sp_deb_q <= sp_deb_d;
    end
  end

  // ----------------------------------------------------------------
  // reply word
  // ----------------------------------------------------------------

  logic [21:0] rd_data;
  lpcfg_reply_s rep;

  // read mux, unused bits and addresses give zero
  always_comb begin
    rd_data = 22'h00_0000;
    // [RQ16] unused bits read zero
    case (frm.addr)
      `LPCFG_ADDR_SG_CUR: begin
        rd_data = 22'(sg_cur_d);
      end
      `LPCFG_ADDR_SP_SLOW: begin
        rd_data = 22'(sp_slow_d);
      end
      `LPCFG_ADDR_SG_SLOW: begin
        rd_data = 22'(sg_slow_d);
      end
      `LPCFG_ADDR_SP_DEB: begin
        rd_data = 22'(sp_deb_d);
      end
      default: begin
        rd_data = 22'h00_0000;
      end
    endcase
  end

  // build reply for the following frame
  always_comb begin
    rep.addr = frm.addr;
    rep.wr = frm.wr;
    // [RQ10] flags above register data
    rep.fault = FAULT_I;
    rep.interrupt_pending_flag = INTERRUPT_PENDING_FLAG_I;
    rep.data = rd_data;
    reply_d = reply_q;
    // [RQ17] reads leave contents unchanged
    if (frame_done) begin
      reply_d = 32'(rep);
    end
  end

  // reply holding flop
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      reply_q <= `LPCFG_REPLY_RST;
    end else begin
      reply_q <= reply_d;
    end
  end

  // miso driven from the shifter only while selected
  assign MISO_O = tx_q[31];
  assign MISO_OE_N_O = cs_s2_q;

  // ----------------------------------------------------------------
  // channel pollers
  // ----------------------------------------------------------------

  // [RQ3] rate tick supplied from outside
  // ground-switch channels, no debounce extension here
  for (genvar g = 0; g < `LPCFG_SG_N; g++) begin : g_sg
    lpcfg_poll_chan #(
      .HAS_DEB(1'b0),
      .ACT_CYC(ACTIVE_CYC),
      .DEB_CYC(DEB_EXT_CYC)
    ) u_chan (
      .clk_i(REF_CLK_I),
      .rst_n_i(RST_N_I),
      .sleep_i(SLEEP_POLLING_STATE_I),
      .tick_i(POLL_TICK_I),
      .slow_i(sg_slow_q[g]),
      .deb_i(1'b0),
      .wet_i(sg_cur_q[g]),
      .batt_i(1'b0),
      .cur_o(SG_CUR_O[g]),
      .sample_o(SG_SAMPLE_O[g]),
      .final_o()
    );
  end

  // programmable channels, wetting select lives elsewhere
  for (genvar p = 0; p < `LPCFG_SP_N; p++) begin : g_sp
    lpcfg_poll_chan #(
      .HAS_DEB(1'b1),
      .ACT_CYC(ACTIVE_CYC),
      .DEB_CYC(DEB_EXT_CYC)
    ) u_chan (
      .clk_i(REF_CLK_I),
      .rst_n_i(RST_N_I),
      .sleep_i(SLEEP_POLLING_STATE_I),
      .tick_i(POLL_TICK_I),
      .slow_i(sp_slow_q[p]),
      .deb_i(sp_deb_q[p]),
      .wet_i(1'b0),
      .batt_i(BATTERY_REFERENCED_SWITCH_I[p]),
      .cur_o(SP_CUR_O[p]),
      .sample_o(SP_SAMPLE_O[p]),
      .final_o(SP_FINAL_O[p])
    );
  end

endmodule

// [bench/lpcfg_top_asserts.sv]
// port-level assertions for the polling config block
`timescale 1ns/10ps
`include "lpcfg_regs.svh"

module lpcfg_top_asserts import lpcfg_pkg::*; #(
  parameter int DEB_EXT_CYC = 120000,
  parameter int ACTIVE_CYC = 64
) (
  // clock and reset
  input wire logic REF_CLK_I,
  input wire logic RST_N_I,
  // serial port and poll control
  input wire logic CS_N_I,
  input wire logic MISO_OE_N_O,
  input wire logic SLEEP_POLLING_STATE_I,
  input wire logic POLL_TICK_I,
  input wire logic [`LPCFG_SP_N-1:0] BATTERY_REFERENCED_SWITCH_I,
  // channel outputs
  input lpcfg_cur_e [`LPCFG_SG_N-1:0] SG_CUR_O,
  input wire logic [`LPCFG_SG_N-1:0] SG_SAMPLE_O,
  input lpcfg_cur_e [`LPCFG_SP_N-1:0] SP_CUR_O,
  input wire logic [`LPCFG_SP_N-1:0] SP_SAMPLE_O,
  input wire logic [`LPCFG_SP_N-1:0] SP_FINAL_O
);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_N_I);
  int sg_on_q, sg_on_d, sp_on_q, sp_on_d;

  // cycles channel 0 has held a current
  always_comb begin
    sg_on_d = (SG_CUR_O[0] != LPCFG_CUR_OFF) ? sg_on_q + 1 : 0;
    sp_on_d = (SP_CUR_O[0] != LPCFG_CUR_OFF) ? sp_on_q + 1 : 0;
  end
  // counter registers
  always_ff @(posedge REF_CLK_I) begin
    sg_on_q <= RST_N_I ? sg_on_d : 0;
    sp_on_q <= RST_N_I ? sp_on_d : 0;
  end

  a_reset_idle: assert property (disable iff (1'b0) !RST_N_I |=> MISO_OE_N_O && SG_CUR_O == '0)
    else $error("not idle in reset");
  a_oe_idle: assert property (CS_N_I [*4] |-> MISO_OE_N_O)
    else $error("miso enabled while idle");
  a_oe_select: assert property ((!CS_N_I) [*4] |-> !MISO_OE_N_O)
    else $error("miso off while selected");
  a_sg_len: assert property (SG_SAMPLE_O[0] |-> sg_on_q == ACTIVE_CYC)
    else $error("sg poll length");
  a_sg_sample: assert property (sg_on_q == ACTIVE_CYC && SG_CUR_O[0] == LPCFG_CUR_OFF
    && SLEEP_POLLING_STATE_I |-> SG_SAMPLE_O[0]) else $error("sg sample missing");
  a_sp_len: assert property (SP_SAMPLE_O[0]
    |-> sp_on_q == (SP_FINAL_O[0] ? ACTIVE_CYC + DEB_EXT_CYC : ACTIVE_CYC)) else $error("sp poll length");
  a_poll_start: assert property (sg_on_q == 0 && SG_CUR_O[0] != LPCFG_CUR_OFF
    |-> $past(POLL_TICK_I) && $past(SLEEP_POLLING_STATE_I)) else $error("poll without tick");
  a_sp_code: assert property (SP_CUR_O[0] != LPCFG_CUR_OFF
    |-> SP_CUR_O[0] == ($past(BATTERY_REFERENCED_SWITCH_I[0]) ? LPCFG_CUR_2MA : LPCFG_CUR_1MA))
    else $error("sp code");

  c_wet_poll: cover property (SG_CUR_O[0] == LPCFG_CUR_WET);
  c_deb_sample: cover property (SP_SAMPLE_O[0] && SP_FINAL_O[0]);
  c_frame_end: cover property (!MISO_OE_N_O ##1 MISO_OE_N_O);
endmodule

bind lpcfg_top lpcfg_top_asserts #(.DEB_EXT_CYC(DEB_EXT_CYC), .ACTIVE_CYC(ACTIVE_CYC)) u_asserts (
  .REF_CLK_I(REF_CLK_I), .RST_N_I(RST_N_I), .CS_N_I(CS_N_I), .MISO_OE_N_O(MISO_OE_N_O),
  .SLEEP_POLLING_STATE_I(SLEEP_POLLING_STATE_I), .POLL_TICK_I(POLL_TICK_I),
  .BATTERY_REFERENCED_SWITCH_I(BATTERY_REFERENCED_SWITCH_I), .SG_CUR_O(SG_CUR_O), .SG_SAMPLE_O(SG_SAMPLE_O),
  .SP_CUR_O(SP_CUR_O), .SP_SAMPLE_O(SP_SAMPLE_O), .SP_FINAL_O(SP_FINAL_O));

// [bench/lpcfg_host.sv]
// host serial master model sending command frames
`timescale 1ns/10ps

module lpcfg_host (
  // clock and reply line
  input wire logic clk_i,
  input wire logic miso_i,
  // serial pins
  output logic sclk_o,
  output logic cs_n_o,
  output logic mosi_o
);
  // idle pins
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end

  // address, write flag, data msb first
  task automatic xfer(input logic [31:0] w, input int nb, input int hold, output logic [31:0] rx);
    rx = 32'h0000_0000;
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    repeat (hold) @(posedge clk_i);
    for (int i = 0; i < nb; i++) begin
      mosi_o <= w[31 - (i % 32)];
      repeat (hold) @(posedge clk_i);
      sclk_o <= 1'b1;
      rx = {rx[30:0], miso_i};
      repeat (hold) @(posedge clk_i);
      sclk_o <= 1'b0;
    end
    repeat (hold) @(posedge clk_i);
    cs_n_o <= 1'b1;
    mosi_o <= ~mosi_o;
    repeat (6) @(posedge clk_i);
  endtask
endmodule

// [bench/lpcfg_top_tb.sv]
// self-checking bench for the polling config block
`timescale 1ns/10ps
`include "lpcfg_regs.svh"

module lpcfg_top_tb import lpcfg_pkg::*;;
  localparam int ACT = 4;
  localparam int DEB = 20;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sclk, cs_n, mosi, miso, miso_oe_n, slow;
  logic fault = 1'b0;
  logic intf = 1'b0;
  logic sleep = 1'b0;
  logic tick = 1'b0;
  logic [11:0] batt = 12'h000;
  lpcfg_cur_e [20:0] sg_cur;
  lpcfg_cur_e [11:0] sp_cur;
  lpcfg_cur_e cur;
  logic [20:0] sg_smp;
  logic [11:0] sp_smp, sp_fin;
  logic [23:0] regs [4] = '{default: 24'h00_0000};
  logic [31:0] exp_q = 32'h0000_0000;
  logic [31:0] rx;
  int on_cnt [33], smp_cnt [33], bad [33];
  int n_errors = 0;
  int total_checks = 0;
  int seed = 32'h0000_c2fe;
  int len;

  always #5 clk = ~clk;

  lpcfg_top #(.DEB_EXT_CYC(DEB), .ACTIVE_CYC(ACT)) dut (
    .REF_CLK_I(clk), .RST_N_I(rst_n), .SCLK_I(sclk), .CS_N_I(cs_n), .MOSI_I(mosi), .MISO_O(miso),
    .MISO_OE_N_O(miso_oe_n), .FAULT_I(fault), .INTERRUPT_PENDING_FLAG_I(intf), .SLEEP_POLLING_STATE_I(sleep),
    .POLL_TICK_I(tick), .BATTERY_REFERENCED_SWITCH_I(batt), .SG_CUR_O(sg_cur), .SG_SAMPLE_O(sg_smp),
    .SP_CUR_O(sp_cur), .SP_SAMPLE_O(sp_smp), .SP_FINAL_O(sp_fin));
  lpcfg_host u_host (.clk_i(clk), .miso_i(miso), .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi));

  // expected current code of a channel
  function automatic lpcfg_cur_e exp_code(input int c);
    if (c < 21) return regs[0][c] ? LPCFG_CUR_WET : LPCFG_CUR_1MA;
    return batt[c-21] ? LPCFG_CUR_2MA : LPCFG_CUR_1MA;
  endfunction

  // implemented bits of each register
  function automatic logic [23:0] impl_mask(input int k);
    return (k == 1 || k == 3) ? 24'h00_0FFF : 24'h1F_FFFF;
  endfunction

  // per-channel poll counters
  always @(posedge clk) begin
    for (int c = 0; c < 33; c++) begin
      cur = (c < 21) ? sg_cur[c] : sp_cur[c-21];
      if (cur != LPCFG_CUR_OFF) on_cnt[c]++;
      if (cur != LPCFG_CUR_OFF && cur !== exp_code(c)) bad[c]++;
      if (((c < 21) ? sg_smp[c] : sp_smp[c-21]) === 1'b1) smp_cnt[c]++;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic summarize();
    if (n_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // one frame; its reply belongs to the previous valid frame
  task automatic frame(input logic [6:0] a, input logic w, input logic [23:0] d, input int nb);
    int k;
    logic f, i;
    k = int'(a) - 23;
    f = 1'($random(seed));
    i = 1'($random(seed));
    @(posedge clk);
    fault <= f;
    intf <= i;
    u_host.xfer({a, w, d}, nb, 5 + ($random(seed) & 3), rx);
    if (nb == 32) begin
      check(rx, exp_q);
      if (w && k >= 0 && k < 4) regs[k] = d & impl_mask(k);
      exp_q = {a, w, f, i, (k >= 0 && k < 4) ? regs[k][21:0] : 22'h00_0000};
    end
  endtask

  // reset, register traffic, then polling
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int k = 0; k < 4; k++) frame(7'(23 + k), 1'b0, 24'hFF_FFFF, 32);
    for (int k = 0; k < 4; k++) frame(7'(23 + k), 1'b1, 24'hFF_FFFF, 32);
    frame(7'h16, 1'b1, 24'hFF_FFFF, 32);
    frame(7'h1B, 1'b1, 24'hFF_FFFF, 32);
    frame(7'h17, 1'b1, 24'h00_0000, 31);
    frame(7'h18, 1'b1, 24'h00_0000, 33);
    for (int k = 0; k < 4; k++) frame(7'(23 + k), 1'b0, 24'h00_0000, 32);
    repeat (12) frame(7'(22 + ($random(seed) & 7)), 1'($random(seed)), 24'($random(seed)), 32);
    for (int k = 0; k < 4; k++) frame(7'(23 + k), 1'b1, 24'($random(seed)) | 24'h00_0001, 32);
    @(posedge clk);
    batt <= 12'($random(seed));
    sleep <= 1'b1;
    for (int t = 0; t < 8; t++) begin
      @(posedge clk);
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
      repeat (30) @(posedge clk);
    end
    for (int c = 0; c < 33; c++) begin
      slow = (c < 21) ? regs[2][c] : regs[1][c-21];
      len = (c >= 21 && regs[3][c-21]) ? ACT + DEB : ACT;
      check(smp_cnt[c], slow ? 8'h02 : 8'h08);
      check(on_cnt[c], (slow ? 2 : 8) * len);
      check(bad[c], 0);
    end
    check(sp_fin, regs[3][11:0]);
    // mid-run reset, then every register must read back cleared
    @(posedge clk);
    sleep <= 1'b0;
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    regs = '{default: 24'h00_0000};
    exp_q = 32'h0000_0000;
    repeat (3) @(posedge clk);
    for (int k = 0; k < 4; k++) frame(7'(23 + k), 1'b0, 24'h00_0000, 32);
    frame(7'h17, 1'b0, 24'h00_0000, 32);
    summarize();
  end

  // hang guard, well beyond the expected run length
  initial begin
    #400_000;
    n_errors++;
    summarize();
  end
endmodule
